/* logic/led_scan_pkg.sv */
// Shared constants for the LED matrix scan core.
package led_scan_pkg;
  // Number of row outputs driven by the core.
  localparam int ROW_COUNT = 28;
  // Number of common outputs driven by the core.
  localparam int COM_COUNT = 8;
  // Width of the display memory address pointer.
  localparam int ADDR_W = 5;
  // Highest valid display memory address.
  localparam logic [4:0] ADDR_LAST = 5'h1b;
  // Address loaded into the pointer after reset.
  localparam logic [4:0] ADDR_RESET = 5'h00;
  // Oscillator cycles spent on one common phase.
  localparam int PHASE_CYCLES = 4160;
  // Width of the phase timer.
  localparam int PHASE_W = 13;
  // Default common count after reset (single bit, 1 selects 8 commons).
  localparam logic COM8_RESET = 1'b1;
  // Settling time before the host may start transfers, in microseconds.
  localparam int INIT_TIME_US = 1000;
  // Clock rate in MHz.
  localparam int CLK_MHZ = 125;
  // Settling time expressed in clock cycles.
  localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
  // Width of the settling counter.
  localparam int INIT_W = 17;
endpackage : led_scan_pkg

/* logic/bit_sync.sv */
// Two-flop synchroniser for a single level.
`timescale 1ns/1ps
module bit_sync (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic d_in,
  output logic q_out
);
  // First stage, read only by the second stage.
  logic meta_r;

  // Register the level through two flops.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= 1'b0;
      q_out <= 1'b0;
    end else if (ce_in) begin
      meta_r <= d_in;
      q_out <= meta_r;
    end
  end
endmodule : bit_sync

/* logic/led_matrix_scan_core.sv */
// LED matrix scan core: display memory, pointer, common scan and thermal shutdown.
//
// Overview of operation
// - Reset restores controls, keeps display memory.
// - Oscillator stopped after reset until started.
// - Outputs high impedance, display off after reset.
// - Active commons selectable as one or eight.
// - All scan timing derives from oscillator clock.
// - Rows come from common phase and data.
// - Eight commons follow selected drive mode.
// - Pointer load, then single or burst writes.
// - Over-temperature sets flag, blanks, kills direct.
// - Release clears flag, restores display, direct.
// - Memory holds 28 bytes; one lights LED.
// - Address n drives row n.
// - D7 drives first common, D0 last.
`timescale 1ns/1ps
module led_matrix_scan_core
  import led_scan_pkg::*;
#(
  parameter int PHASE_LEN = PHASE_CYCLES,
  parameter int INIT_LEN = INIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  input wire logic osc_start_in,
  input wire logic osc_stop_in,
  input wire logic display_on_in,
  input wire logic display_off_in,
  input wire logic com8_sel_in,
  input wire logic com_cfg_we_in,
  input wire logic ptr_load_in,
  input wire logic [ADDR_W-1:0] ptr_addr_in,
  input wire logic data_we_in,
  input wire logic [7:0] data_in,
  input wire logic direct_in,
  input wire logic over_temp_in,
  output logic [ROW_COUNT-1:0] row_outputs_out,
  output logic [ROW_COUNT-1:0] row_oe_out,
  output logic [COM_COUNT-1:0] common_outputs_out,
  output logic [COM_COUNT-1:0] common_oe_out,
  output logic direct_out,
  output logic direct_oe_out,
  output logic thermal_shutdown_flag_out,
  output logic osc_running_out,
  output logic init_done_out,
  output logic [ADDR_W-1:0] ptr_out
);
  // Scan state machine, one-hot.
  typedef enum logic [1:0] {
    SCAN_IDLE = 2'b01,
    SCAN_RUN = 2'b10
  } scan_type;

  // Complete control state held in one packed record.
  typedef struct packed {
    scan_type scan;
    logic osc_on;
    logic disp_on;
    logic com8;
    logic shutdown;
    logic init_done;
    logic [INIT_W-1:0] init_cnt;
    logic [PHASE_W-1:0] phase_cnt;
    logic [2:0] com_idx;
    logic [ADDR_W-1:0] ptr;
    logic [ROW_COUNT-1:0] rows;
    logic [ROW_COUNT-1:0] row_oe;
    logic [COM_COUNT-1:0] coms;
    logic [COM_COUNT-1:0] com_oe;
    logic direct;
    logic direct_oe;
  } state_type;

  // Display memory, kept apart so reset leaves its contents alone.
  logic [7:0] display_data_memory [ROW_COUNT];
  // Registered state and its next value.
  state_type st_r;
  state_type st_nxt;
  // Synchronised over-temperature level.
  logic hot_sync;

  // Reset value of the control record.
  localparam state_type ST_RESET = '{
    scan: SCAN_IDLE, osc_on: 1'b0, disp_on: 1'b0, com8: COM8_RESET, shutdown: 1'b0,
    init_done: 1'b0, init_cnt: '0, phase_cnt: '0, com_idx: 3'h0, ptr: ADDR_RESET,
    rows: '0, row_oe: '0, coms: '0, com_oe: '0, direct: 1'b0, direct_oe: 1'b0};

  // Pick the data bit of a memory word for a given common index.
  function automatic logic com_bit(input logic [7:0] word, input logic [2:0] idx);
    com_bit = word[3'h7 - idx];
  endfunction : com_bit

  bit_sync u_hot_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce_in),
    .d_in(over_temp_in),
    .q_out(hot_sync)
  );

  always_ff @(posedge clk_in) begin
    if (ce_in && data_we_in && !ptr_load_in && st_r.ptr <= ADDR_LAST) begin
      display_data_memory[st_r.ptr] <= data_in;
    end
  end

  // Next-state logic for the whole control record.
  always_comb begin
    logic lit;
    logic active;
    logic [2:0] eff_idx;
    lit = 1'b0;
    active = 1'b0;
    eff_idx = 3'h0;
    st_nxt = st_r;
    // Settling counter marks when the host may start talking.
    if (!st_r.init_done) begin
      if (st_r.init_cnt == INIT_W'(INIT_LEN - 1)) begin
        st_nxt.init_done = 1'b1;
      end else begin
        st_nxt.init_cnt = st_r.init_cnt + INIT_W'(1);
      end
    end
    if (osc_start_in) begin
      st_nxt.osc_on = 1'b1;
    end else if (osc_stop_in) begin
      st_nxt.osc_on = 1'b0;
    end
    // Display on and off commands.
    if (display_on_in) begin
      st_nxt.disp_on = 1'b1;
    end else if (display_off_in) begin
      st_nxt.disp_on = 1'b0;
    end
    if (com_cfg_we_in) begin
      st_nxt.com8 = com8_sel_in;
    end
    if (ptr_load_in) begin
      st_nxt.ptr = ptr_addr_in;
    end else if (data_we_in) begin
      st_nxt.ptr = (st_r.ptr >= ADDR_LAST) ? ADDR_RESET : st_r.ptr + ADDR_W'(1);
    end
    st_nxt.shutdown = hot_sync;
    unique case (st_r.scan)
      SCAN_IDLE: begin
        st_nxt.phase_cnt = '0;
        st_nxt.com_idx = 3'h0;
        if (st_r.osc_on) begin
          st_nxt.scan = SCAN_RUN;
        end
      end
      SCAN_RUN: begin
        if (!st_r.osc_on) begin
          st_nxt.scan = SCAN_IDLE;
        end else if (st_r.phase_cnt == PHASE_W'(PHASE_LEN - 1)) begin
          st_nxt.phase_cnt = '0;
          // One-common mode stays on the first common.
          st_nxt.com_idx = st_r.com8 ? st_r.com_idx + 3'h1 : 3'h0;
        end else begin
          st_nxt.phase_cnt = st_r.phase_cnt + PHASE_W'(1);
        end
      end
    endcase
    active = st_r.osc_on && st_r.disp_on && !st_r.shutdown && (st_r.scan == SCAN_RUN);
    // Single mode scans common zero
    // A stale index left from eight-common mode must never light another common.
    eff_idx = st_r.com8 ? st_r.com_idx : 3'h0;
    for (int c = 0; c < COM_COUNT; c++) begin
      st_nxt.coms[c] = active && (eff_idx == 3'(c));
      st_nxt.com_oe[c] = active && (st_r.com8 || c == 0);
    end
    for (int r = 0; r < ROW_COUNT; r++) begin
      lit = com_bit(display_data_memory[r], eff_idx);
      st_nxt.rows[r] = active && lit;
      st_nxt.row_oe[r] = active;
    end
    st_nxt.direct = st_r.osc_on && !st_r.shutdown && direct_in;
    st_nxt.direct_oe = st_r.osc_on && !st_r.shutdown;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_r <= ST_RESET;
    end else if (ce_in) begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the record flops.
  assign row_outputs_out = st_r.rows;
  assign row_oe_out = st_r.row_oe;
  assign common_outputs_out = st_r.coms;
  assign common_oe_out = st_r.com_oe;
  assign direct_out = st_r.direct;
  assign direct_oe_out = st_r.direct_oe;
  assign thermal_shutdown_flag_out = st_r.shutdown;
  assign osc_running_out = st_r.osc_on;
  assign init_done_out = st_r.init_done;
  assign ptr_out = st_r.ptr;

  flag_follow_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in |=> thermal_shutdown_flag_out == $past(hot_sync))
    else $error("shutdown flag lags detector");
  hot_blank_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    thermal_shutdown_flag_out && ce_in |=> common_oe_out == '0)
    else $error("commons driven while hot");
  hot_direct_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    thermal_shutdown_flag_out && ce_in |=> !direct_oe_out)
    else $error("direct pin driven while hot");
  cool_direct_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !thermal_shutdown_flag_out && osc_running_out && ce_in |=> direct_oe_out)
    else $error("direct pin not restored");
  direct_follow_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && osc_running_out && !thermal_shutdown_flag_out
      |=> direct_out == $past(direct_in))
    else $error("direct pin lost its level");
  osc_stop_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !osc_running_out && ce_in |=> row_oe_out == '0)
    else $error("rows driven while stopped");
  osc_run_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && osc_start_in |=> osc_running_out)
    else $error("oscillator did not start");
  osc_halt_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && osc_stop_in && !osc_start_in |=> !osc_running_out)
    else $error("oscillator did not stop");
  one_com_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $onehot0(common_outputs_out))
    else $error("several commons lit");
  com_one_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !st_r.com8 && ce_in |=> common_oe_out[COM_COUNT-1:1] == '0)
    else $error("extra commons in single mode");
  one_mode_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !st_r.com8 && ce_in |=> common_outputs_out[COM_COUNT-1:1] == '0)
    else $error("extra common lit in single mode");
  com_cfg_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && com_cfg_we_in |=> st_r.com8 == $past(com8_sel_in))
    else $error("common count not taken");
  // A running phase that has not reached its last cycle.
  sequence phase_hold_s;
    ce_in && st_r.osc_on && (st_r.scan == SCAN_RUN) &&
      (st_r.phase_cnt != PHASE_W'(PHASE_LEN - 1));
  endsequence
  // The last cycle of a running phase in eight-common mode.
  sequence phase_wrap_s;
    ce_in && st_r.osc_on && st_r.com8 && (st_r.scan == SCAN_RUN) &&
      (st_r.phase_cnt == PHASE_W'(PHASE_LEN - 1));
  endsequence
  com_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_hold_s |=> st_r.com_idx == $past(st_r.com_idx))
    else $error("common moved inside a phase");
  com_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    phase_wrap_s |=> st_r.com_idx == $past(st_r.com_idx) + 3'h1)
    else $error("common did not step");
  ptr_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && data_we_in && !ptr_load_in && ptr_out < ADDR_LAST
      |=> ptr_out == $past(ptr_out) + ADDR_W'(1))
    else $error("pointer did not advance");
  ptr_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && ptr_load_in |=> ptr_out == $past(ptr_addr_in))
    else $error("pointer load lost");
  row_com_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    row_outputs_out != '0 |-> common_outputs_out != '0)
    else $error("row lit without common");
  row_drive_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (row_outputs_out & ~row_oe_out) == '0)
    else $error("row lit while released");
endmodule : led_matrix_scan_core

/* testbench/led_host_model.sv */
// Host controller model that issues commands and display data to the scan core.
`timescale 1ns/1ps
module led_host_model
  import led_scan_pkg::*;
(
  input wire logic clk_in,
  input wire logic init_done_in,
  output logic osc_start_out,
  output logic osc_stop_out,
  output logic display_on_out,
  output logic display_off_out,
  output logic com8_sel_out,
  output logic com_cfg_we_out,
  output logic ptr_load_out,
  output logic [ADDR_W-1:0] ptr_addr_out,
  output logic data_we_out,
  output logic [7:0] data_out
);
  // All command strobes idle from time zero.
  initial begin
    {osc_start_out, osc_stop_out, display_on_out, display_off_out} = 4'h0;
    {com8_sel_out, com_cfg_we_out, ptr_load_out, data_we_out} = 4'h8;
    ptr_addr_out = 5'h00;
    data_out = 8'h00;
  end
  // Hold off traffic
  // Waits for the settling flag, bounded, before any transfer is sent.
  task automatic wait_ready();
    int n;
    n = 0;
    while (init_done_in !== 1'b1 && n < 200) begin
      @(posedge clk_in);
      n++;
    end
    @(posedge clk_in);
  endtask : wait_ready
  // Starts the oscillator, then turns the display on, as two one-cycle pulses.
  task automatic start_display();
    @(posedge clk_in); #1 osc_start_out = 1'b1;
    @(posedge clk_in); #1 osc_start_out = 1'b0;
    display_on_out = 1'b1;
    @(posedge clk_in); #1 display_on_out = 1'b0;
  endtask : start_display
  // Turns the display off and stops the oscillator in one cycle.
  task automatic stop_display();
    @(posedge clk_in); #1 {osc_stop_out, display_off_out} = 2'h3;
    @(posedge clk_in); #1 {osc_stop_out, display_off_out} = 2'h0;
  endtask : stop_display
  // Selects eight commons when eight is high, else one common.
  task automatic set_coms(input logic eight);
    @(posedge clk_in); #1 com8_sel_out = eight;
    com_cfg_we_out = 1'b1;
    @(posedge clk_in); #1 com_cfg_we_out = 1'b0;
  endtask : set_coms
  // Pointer then data
  // Loads the pointer, then sends the bytes back to back with the strobe held.
  task automatic write_seq(input logic [ADDR_W-1:0] a, input logic [7:0] q[$]);
    @(posedge clk_in); #1 ptr_load_out = 1'b1;
    ptr_addr_out = a;
    @(posedge clk_in); #1 ptr_load_out = 1'b0;
    foreach (q[i]) begin
      data_we_out = 1'b1;
      data_out = q[i];
      @(posedge clk_in); #1;
    end
    data_we_out = 1'b0;
  endtask : write_seq
endmodule : led_host_model

/* testbench/led_matrix_scan_core_tb.sv */
// Self-checking testbench for the LED matrix scan core.
`timescale 1ns/1ps
module led_matrix_scan_core_tb;
  import led_scan_pkg::*;
  localparam int PL = 8;
  logic clk_in, rst_b_in, direct_in, over_temp_in;
  logic osc_start, osc_stop, disp_on, disp_off, com8_sel, com_cfg_we, ptr_load, data_we;
  logic [ADDR_W-1:0] ptr_addr, ptr_out;
  logic [7:0] data;
  logic [ROW_COUNT-1:0] row_outputs_out, row_oe_out;
  logic [COM_COUNT-1:0] common_outputs_out, common_oe_out;
  logic direct_out, direct_oe_out, flag_out, osc_running_out, init_done_out;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] mem [ROW_COUNT];
  logic [7:0] q [$];
  logic ce;
  led_host_model host (.clk_in(clk_in), .init_done_in(init_done_out),
    .osc_start_out(osc_start), .osc_stop_out(osc_stop), .display_on_out(disp_on),
    .display_off_out(disp_off), .com8_sel_out(com8_sel), .com_cfg_we_out(com_cfg_we),
    .ptr_load_out(ptr_load), .ptr_addr_out(ptr_addr), .data_we_out(data_we), .data_out(data));
  led_matrix_scan_core #(.PHASE_LEN(PL), .INIT_LEN(16)) dut (.clk_in(clk_in),
    .rst_b_in(rst_b_in), .ce_in(ce), .osc_start_in(osc_start), .osc_stop_in(osc_stop),
    .display_on_in(disp_on), .display_off_in(disp_off), .com8_sel_in(com8_sel),
    .com_cfg_we_in(com_cfg_we), .ptr_load_in(ptr_load), .ptr_addr_in(ptr_addr),
    .data_we_in(data_we), .data_in(data), .direct_in(direct_in), .over_temp_in(over_temp_in),
    .row_outputs_out(row_outputs_out), .row_oe_out(row_oe_out),
    .common_outputs_out(common_outputs_out), .common_oe_out(common_oe_out),
    .direct_out(direct_out), .direct_oe_out(direct_oe_out),
    .thermal_shutdown_flag_out(flag_out), .osc_running_out(osc_running_out),
    .init_done_out(init_done_out), .ptr_out(ptr_out));
  // Free-running 125 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  // Compares one value and reports a difference at once.
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("comparisons=%0d mismatches=%0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict
  // Holds reset for eight cycles and checks the quiet state of the output enables, oscillator, pointer and settling flag.
  task automatic do_reset();
    @(posedge clk_in); #1 rst_b_in = 1'b0;
    repeat (8) @(posedge clk_in);
    #1 check({row_oe_out, common_oe_out, direct_oe_out, osc_running_out}, 0);
    check(ptr_out, 0);
    check(init_done_out, 0);
    rst_b_in = 1'b1;
    repeat (15) @(posedge clk_in);
    #1 check(init_done_out, 0);
    host.wait_ready();
    #1 check(osc_running_out, 0);
    check(init_done_out, 1);
  endtask : do_reset
  // Fills the whole memory, checks the wrap, then rewrites the last two rows.
  task automatic fill_memory();
    q = {};
    for (int r = 0; r < ROW_COUNT; r++) begin
      mem[r] = 8'(r * 37 + 19);
      q.push_back(mem[r]);
    end
    host.write_seq(5'h00, q);
    check(ptr_out, 0);
    mem[26] = 8'h81;
    mem[27] = 8'h7e;
    q = {8'h81, 8'h7e};
    host.write_seq(5'h1a, q);
    check(ptr_out, 0);
    // A write past the last row is dropped, but the pointer still wraps.
    q = {8'hff};
    host.write_seq(5'h1f, q);
    check(ptr_out, 0);
  endtask : fill_memory
  // Follows nine phases and checks each common against its data bit per row.
  task automatic scan_check();
    int n;
    int k;
    logic [COM_COUNT-1:0] prev;
    logic [ROW_COUNT-1:0] exp;
    prev = common_outputs_out;
    for (int p = 0; p < 9; p++) begin
      n = 0;
      while (common_outputs_out === prev && n < 4 * PL) begin
        @(posedge clk_in); #1 n++;
      end
      if (p > 1) check(n + 4, PL);
      repeat (4) @(posedge clk_in);
      #1 prev = common_outputs_out;
      check($countones(prev), 1);
      check({row_oe_out, common_oe_out}, {ROW_COUNT + COM_COUNT{1'b1}});
      k = 0;
      for (int i = 0; i < COM_COUNT; i++) if (prev[i] === 1'b1) k = i;
      for (int r = 0; r < ROW_COUNT; r++) exp[r] = mem[r][7 - k];
      check(row_outputs_out, exp);
    end
  endtask : scan_check
  // One-common mode must keep only the first common lit.
  task automatic one_common_check();
    host.set_coms(1'b0);
    repeat (3) @(posedge clk_in);
    repeat (3 * PL) begin
      @(posedge clk_in); #1 check(common_outputs_out & 8'hfe, 0);
      check(common_outputs_out, 8'h01);
    end
    host.set_coms(1'b1);
  endtask : one_common_check
  // Dropping the clock enable must freeze the scan and the pointer.
  task automatic ce_check();
    logic [COM_COUNT-1:0] held;
    logic [ADDR_W-1:0] ptr_held;
    @(posedge clk_in); #1 ce = 1'b0;
    held = common_outputs_out;
    ptr_held = ptr_out;
    repeat (3 * PL) @(posedge clk_in);
    #1 check({common_outputs_out, ptr_out}, {held, ptr_held});
    ce = 1'b1;
  endtask : ce_check
  // Heats and cools the die and watches the flag, rows and direct pin.
  task automatic thermal_check();
    @(posedge clk_in); #1 over_temp_in = 1'b1;
    repeat (6) @(posedge clk_in);
    #1 check(flag_out, 1);
    check({row_outputs_out & row_oe_out, direct_oe_out}, 0);
    over_temp_in = 1'b0;
    repeat (6) @(posedge clk_in);
    #1 check({flag_out, direct_oe_out, direct_out}, 3'h3);
    check(row_oe_out, {ROW_COUNT{1'b1}});
  endtask : thermal_check
  // Main sequence; a second reset shows that display data survives it.
  initial begin
    {rst_b_in, direct_in, over_temp_in, ce} = 4'h5;
    do_reset();
    fill_memory();
    host.start_display();
    scan_check();
    one_common_check();
    ce_check();
    thermal_check();
    host.stop_display();
    #1 check(osc_running_out, 0);
    do_reset();
    host.start_display();
    scan_check();
    give_verdict();
  end
  // Cuts a hang short after about ten times the expected run length.
  initial begin
    repeat (3000) @(posedge clk_in);
    miscompares++;
    give_verdict();
  end
endmodule : led_matrix_scan_core_tb
